// ---- ddsc_params.svh ----
// Constants for the dual DAC serial command controller: field positions and timing.
// Assumes inclusion by the package and the top module of this block only.
`ifndef DDSC_PARAMS_SVH
`define DDSC_PARAMS_SVH

// ====================================================================
// Command word layout
`define DDSC_WORD_BITS     24
`define DDSC_DATA_BITS     16
`define DDSC_BIT_RSVD_HI   23
`define DDSC_BIT_RSVD_LO   22
`define DDSC_BIT_LOAD_B    21
`define DDSC_BIT_LOAD_A    20
`define DDSC_BIT_DONT_CARE 19
`define DDSC_BIT_BUF_SEL   18
`define DDSC_BIT_PWRDN1    17
`define DDSC_BIT_PWRDN0    16

// ====================================================================
// Reset value and last shift count
`define DDSC_DAC_RESET     16'h0000
`define DDSC_COUNT_LAST    5'h17

// ====================================================================
// Timing
`define DDSC_CLK_PERIOD_NS 8
`define DDSC_GAP_NS        100

`endif

// ---- ddsc_pkg.sv ----
// Types shared by the dual DAC serial command controller.
// Assumes ddsc_params.svh is on the include path.
`include "ddsc_params.svh"

package ddsc_pkg;

  // ==================================================================
  // Operating mode per channel
  typedef enum logic [1:0] {
    DDSC_MODE_NORMAL = 2'b00,
    DDSC_MODE_PD_1K  = 2'b01,
    DDSC_MODE_PD_100K = 2'b10,
    DDSC_MODE_PD_HIZ = 2'b11
  } ddsc_mode_t;

  // ==================================================================
  // Decoded command word
  typedef struct packed {
    logic [1:0]  reserved;
    logic        load_b_bit;
    logic        load_a_bit;
    logic        dont_care;
    logic        buffer_select;
    ddsc_mode_t  pwrdn_sel;
    logic [15:0] data;
  } ddsc_cmd_t;

  // ==================================================================
  // Per-channel buffer and output state
  typedef struct packed {
    ddsc_mode_t  mode;
    logic [15:0] code;
  } ddsc_chan_t;

  // ==================================================================
  // Receive state
  typedef enum logic [1:0] {
    DDSC_IDLE   = 2'b00,
    DDSC_SHIFT  = 2'b01,
    DDSC_LOCKED = 2'b10
  } ddsc_state_t;

endpackage

// ---- ddsc_ctrl.sv ----
// Dual DAC serial command controller: three-wire receiver, buffers, DAC registers.
// Assumes the serial pins come from another clock domain and are synchronised here.
// What this block does
// - Frame sync going low opens the input shift register.
// - While sync is low, one data bit shifts in each falling serial clock.
// - At the 24th falling edge the shift register locks; further edges ignored.
// - Upper eight bits are control, lower sixteen bits are data.
// - Command executes right after the 24th edge, not waiting for sync high.
// - A new transaction begins only at the next falling edge of sync.
// - Sync rising before the 24th edge discards the frame with no effect.
// - Load bits for A and B update that channel's output.
// - The don't-care control bit has no effect.
// - Buffer select picks which channel buffer receives the word.
// - Mode bits are written into the addressed buffer with it.
// - Mode 00 normal, 01 1k to ground, 10 100k, 11 high impedance.
// - Data goes to the selected buffer and DAC register per control byte.
// - At reset both DAC registers are zero until a load reaches them.
// - Power-down takes effect only when the channel is loaded.
// - In power-down the output switches to the selected termination.
// - Leaving power-down needs mode 00, new data and a load.
// - DAC code is unsigned binary; output is reference times code over 65536.
// - Each channel keeps its own mode independently.
// - A load copies the channel buffer into its DAC register.
// - Buffer select 0 addresses A, 1 addresses B.
`timescale 1ns/100ps
`include "ddsc_params.svh"

module ddsc_ctrl #(
  parameter int NUM_CH = 2
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                sync_n,
  input  wire logic                sclk,
  input  wire logic                din,
  output logic [NUM_CH-1:0][15:0]  dac_code,
  output ddsc_pkg::ddsc_mode_t [NUM_CH-1:0] dac_mode,
  output logic [NUM_CH-1:0]        out_amp_on,
  output logic [NUM_CH-1:0]        term_1k_on,
  output logic [NUM_CH-1:0]        term_100k_on,
  output logic                     cmd_done,
  output logic                     frame_abort
);

  // ==================================================================
  // Pin synchronisers
  logic [2:0] sync_meta_ff;
  logic [2:0] sync_pin_ff;
  logic       sclk_prev_ff;
  logic       sync_prev_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_meta_ff <= 3'h7;
      sync_pin_ff  <= 3'h7;
      sclk_prev_ff <= 1'h1;
      sync_prev_ff <= 1'h1;
    end else begin
      sync_meta_ff <= {sync_n, sclk, din};
      sync_pin_ff  <= sync_meta_ff;
      sclk_prev_ff <= sync_pin_ff[1];
      sync_prev_ff <= sync_pin_ff[2];
    end
  end

  logic sync_lo;
  logic sclk_s;
  logic din_s;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;

  assign sync_lo   = ~sync_pin_ff[2];
  assign sclk_s    = sync_pin_ff[1];
  assign din_s     = sync_pin_ff[0];
  assign sclk_fall = sclk_prev_ff & ~sclk_s;
  assign sync_fall = sync_prev_ff & ~sync_pin_ff[2];
  assign sync_rise = ~sync_prev_ff & sync_pin_ff[2];

  // ==================================================================
  // Receive state machine and shift register
  ddsc_pkg::ddsc_state_t state_ff;
  ddsc_pkg::ddsc_state_t nxt_state;
  logic [`DDSC_WORD_BITS-1:0] shift_ff;
  logic [`DDSC_WORD_BITS-1:0] nxt_shift;
  logic [4:0] count_ff;
  logic [4:0] nxt_count;
  logic       exec_ff;
  logic       nxt_exec;
  logic       abort_ff;
  logic       nxt_abort;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_count = count_ff;
    nxt_exec  = 1'b0;
    nxt_abort = 1'b0;
    case (state_ff)
      ddsc_pkg::DDSC_IDLE: begin
        if (sync_fall) begin
          nxt_state = ddsc_pkg::DDSC_SHIFT;
          nxt_shift = '0;
          nxt_count = 5'h00;
        end
      end
      ddsc_pkg::DDSC_SHIFT: begin
        if (!sync_lo) begin
          nxt_state = ddsc_pkg::DDSC_IDLE;
          nxt_shift = '0;
          nxt_count = 5'h00;
          nxt_abort = 1'b1;
        end else if (sclk_fall) begin
          nxt_shift = {shift_ff[`DDSC_WORD_BITS-2:0], din_s};
          nxt_count = count_ff + 5'h01;
          if (count_ff == `DDSC_COUNT_LAST) begin
            nxt_state = ddsc_pkg::DDSC_LOCKED;
            nxt_exec  = 1'b1;
          end
        end
      end
      ddsc_pkg::DDSC_LOCKED: begin
        // Further clocks are ignored; a sync rise or fall ends the frame.
        if (sync_rise) begin
          nxt_state = ddsc_pkg::DDSC_IDLE;
        end else if (sync_fall) begin
          nxt_state = ddsc_pkg::DDSC_SHIFT;
          nxt_shift = '0;
          nxt_count = 5'h00;
        end
      end
      default: begin
        nxt_state = ddsc_pkg::DDSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ddsc_pkg::DDSC_IDLE;
      shift_ff <= '0;
      count_ff <= 5'h00;
      exec_ff  <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
      exec_ff  <= nxt_exec;
      abort_ff <= nxt_abort;
    end
  end

  // ==================================================================
  // Command decode and channel update
  ddsc_pkg::ddsc_cmd_t cmd;
  assign cmd = ddsc_pkg::ddsc_cmd_t'(shift_ff);

  ddsc_pkg::ddsc_chan_t [NUM_CH-1:0] buf_ff;
  ddsc_pkg::ddsc_chan_t [NUM_CH-1:0] nxt_buf;
  ddsc_pkg::ddsc_chan_t [NUM_CH-1:0] dac_ff;
  ddsc_pkg::ddsc_chan_t [NUM_CH-1:0] nxt_dac;
  logic [NUM_CH-1:0] load_req;

  assign load_req = NUM_CH'({cmd.load_b_bit, cmd.load_a_bit});

  always_comb begin
    nxt_buf = buf_ff;
    nxt_dac = dac_ff;
    if (exec_ff) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (int'(cmd.buffer_select) == i) begin
          nxt_buf[i].mode = cmd.pwrdn_sel;
          nxt_buf[i].code = cmd.data;
        end
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (load_req[i]) begin
          nxt_dac[i] = nxt_buf[i];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        buf_ff[i] <= '{mode: ddsc_pkg::DDSC_MODE_NORMAL, code: `DDSC_DAC_RESET};
        dac_ff[i] <= '{mode: ddsc_pkg::DDSC_MODE_NORMAL, code: `DDSC_DAC_RESET};
      end
    end else begin
      buf_ff <= nxt_buf;
      dac_ff <= nxt_dac;
    end
  end

  // ==================================================================
  // Outputs: code is straight binary; termination per channel mode
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign dac_code[g]     = dac_ff[g].code;
      assign dac_mode[g]     = dac_ff[g].mode;
      assign out_amp_on[g]   = dac_ff[g].mode == ddsc_pkg::DDSC_MODE_NORMAL;
      assign term_1k_on[g]   = dac_ff[g].mode == ddsc_pkg::DDSC_MODE_PD_1K;
      assign term_100k_on[g] = dac_ff[g].mode == ddsc_pkg::DDSC_MODE_PD_100K;
    end
  endgenerate

  assign cmd_done    = exec_ff;
  assign frame_abort = abort_ff;

endmodule // ddsc_ctrl

// ---- ddsc_ctrl_assertions.sv ----
// Checker for ddsc_ctrl, bound to its ports.
// Assumes pins idle high between frames and sclk phases of 3 clk or more.
`timescale 1ns/100ps
module ddsc_ctrl_assertions #(
  parameter int NUM_CH = 2
) (
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              sync_n,
  input wire logic                              sclk,
  input wire logic                              din,
  input wire logic [NUM_CH-1:0][15:0]           dac_code,
  input wire ddsc_pkg::ddsc_mode_t [NUM_CH-1:0] dac_mode,
  input wire logic [NUM_CH-1:0]                 out_amp_on,
  input wire logic [NUM_CH-1:0]                 term_1k_on,
  input wire logic [NUM_CH-1:0]                 term_100k_on,
  input wire logic                              cmd_done,
  input wire logic                              frame_abort
);
  logic [NUM_CH-1:0] amp_x;
  logic [NUM_CH-1:0] t1k_x;
  logic [NUM_CH-1:0] t100k_x;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      amp_x[i]   = dac_mode[i] == ddsc_pkg::DDSC_MODE_NORMAL;
      t1k_x[i]   = dac_mode[i] == ddsc_pkg::DDSC_MODE_PD_1K;
      t100k_x[i] = dac_mode[i] == ddsc_pkg::DDSC_MODE_PD_100K;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_amp_map: assert property (out_amp_on == amp_x)
    else $error("amplifier enable wrong");
  a_t1k_map: assert property (term_1k_on == t1k_x)
    else $error("1k termination wrong");
  a_t100k_map: assert property (term_100k_on == t100k_x)
    else $error("100k termination wrong");
  // The DAC registers take their new value on the edge that ends the cmd_done cycle.
  a_code_hold: assert property (!$past(cmd_done) |-> $stable(dac_code))
    else $error("code moved without command");
  a_mode_hold: assert property ($changed(dac_mode) |-> $past(cmd_done))
    else $error("mode moved without command");
  a_done_gap: assert property (cmd_done |=> !cmd_done [*8])
    else $error("command pulses too close");
  a_abort_quiet: assert property (frame_abort |-> !cmd_done [*8])
    else $error("abort with command");
  a_idle_quiet: assert property (sync_n [*8] |=> !cmd_done && !frame_abort)
    else $error("activity while sync idle");
  c_done: cover property (cmd_done);
  c_abort: cover property (frame_abort);
  c_hiz: cover property (dac_mode[0] == ddsc_pkg::DDSC_MODE_PD_HIZ);
  c_pd_b: cover property (dac_mode[1] == ddsc_pkg::DDSC_MODE_PD_100K);
endmodule // ddsc_ctrl_assertions

bind ddsc_ctrl ddsc_ctrl_assertions #(.NUM_CH(NUM_CH)) u_chk (.clk(clk), .rst(rst),
  .sync_n(sync_n), .sclk(sclk), .din(din), .dac_code(dac_code), .dac_mode(dac_mode),
  .out_amp_on(out_amp_on), .term_1k_on(term_1k_on), .term_100k_on(term_100k_on),
  .cmd_done(cmd_done), .frame_abort(frame_abort));

// ---- ddsc_host_model.sv ----
// Serial host model: sends command words on sync_n, sclk and din.
// Assumes a 125 MHz clk; sclk runs at 64 ns only inside frames.
`timescale 1ns/100ps
module ddsc_host_model (
  input wire logic clk,
  output logic     sync_n,
  output logic     sclk,
  output logic     din
);
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    din    = 1'b0;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Sends n bits, wrapping past 24; hold keeps sync low after the word.
  task automatic send(input logic [23:0] w, input int n, input bit hold);
    sync_n <= 1'b1;
    tick(16);
    sync_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      din <= w[23-(i%24)];
      tick(4);
      sclk <= 1'b0;
      tick(4);
      sclk <= 1'b1;
    end
    tick(12);
    din <= ~din;
    if (!hold) sync_n <= 1'b1;
  endtask
endmodule // ddsc_host_model

// ---- tb_top.sv ----
// Testbench for ddsc_ctrl: host model writes words, outputs checked.
// Assumes the host model and checker bind are compiled with the design.
`timescale 1ns/100ps
module tb_top;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       sync_n, sclk, din, cmd_done, frame_abort;
  logic [1:0][15:0]           dac_code;
  ddsc_pkg::ddsc_mode_t [1:0] dac_mode;
  logic [1:0]                 out_amp_on, term_1k_on, term_100k_on;
  logic [17:0]                bufm [2];
  logic [17:0]                outm [2];
  int bad_count, check_count, n_done, n_abort, e_done, e_abort, cyc;
  always #4 clk = ~clk;
  ddsc_host_model host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
  ddsc_ctrl #(.NUM_CH(2)) dut (.clk(clk), .rst(rst), .sync_n(sync_n), .sclk(sclk),
    .din(din), .dac_code(dac_code), .dac_mode(dac_mode), .out_amp_on(out_amp_on),
    .term_1k_on(term_1k_on), .term_100k_on(term_100k_on), .cmd_done(cmd_done),
    .frame_abort(frame_abort));
  task automatic wrap_up();
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    n_done <= n_done + int'(cmd_done === 1'b1);
    n_abort <= n_abort + int'(frame_abort === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sends one word, updates the expected state, then compares outputs and pulses.
  // Waits for the abort pulse of a cut frame to be counted before comparing.
  task automatic wr(input logic [23:0] w, input int n = 24, input bit hold = 1'b0);
    logic [5:0] tx;
    host.send(w, n, hold);
    repeat (6) @(posedge clk);
    if (n >= 24) begin
      bufm[w[18]] = w[17:0];
      if (w[20]) outm[0] = bufm[0];
      if (w[21]) outm[1] = bufm[1];
      e_done++;
    end else e_abort++;
    chk({dac_mode[1], dac_code[1], dac_mode[0], dac_code[0]},
        {outm[1], outm[0]});
    chk({18'(n_done), 18'(n_abort)}, {18'(e_done), 18'(e_abort)});
    for (int i = 0; i < 2; i++) begin
      tx[i]   = outm[i][17:16] == 2'b00;
      tx[i+2] = outm[i][17:16] == 2'b01;
      tx[i+4] = outm[i][17:16] == 2'b10;
    end
    chk({30'h0, term_100k_on, term_1k_on, out_amp_on}, {30'h0, tx});
  endtask
  initial begin
    bufm = '{18'h0, 18'h0};
    outm = bufm;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(24'h001234);
    wr(24'h34abcd, 24, 1'b1);
    wr(24'h18ffff, 25);
    wr(24'h100001, 10);
    for (int m = 0; m < 4; m++) begin
      wr({6'h04, 2'(m), 16'h0000});
      chk({33'h0, out_amp_on[0], term_1k_on[0], term_100k_on[0]},
          {33'h0, m == 0, m == 1, m == 2});
    end
    wr(24'h060000);
    wr(24'h285555);
    wr(24'h105555);
    wr(24'h24beef);
    wrap_up();
  end
endmodule // tb_top
